// File: bench/fcs_array_model.sv
/* array model: ends busy operations after a chosen delay, fills the
   program buffer, raises supply faults. assumes fcs_regs.vh state codes */
`include "fcs_regs.vh"
`default_nettype none
// ---------------------------------------------------------------------
// array model
// ---------------------------------------------------------------------
module fcs_array_model (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset, active low
  input wire logic [15:0] state_r, // sequencer state
  input wire logic [3:0] dly, // cycles before an op ends
  input wire logic err, // fault while busy
  output logic op_done, // op finished
  output logic buf_full, // buffer complete
  output logic vpp_bad // supply fault
);
  logic [3:0] cnt_r;
  wire busy = |(state_r & 16'h9208);
  wire load = state_r == `FCS_S_BP_LOAD2;
  // leaving busy restarts the count, so a resumed op runs its full time
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) cnt_r <= 4'h0;
    else if (!busy && !load) cnt_r <= 4'h0;
    else if (cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
  end
  assign op_done = busy && cnt_r == dly;
  assign buf_full = load && cnt_r >= dly;
  assign vpp_bad = busy && err;
endmodule // fcs_array_model
`default_nettype wire

// File: bench/fcs_seq_asserts.sv
/* port checker for the flash command sequencer.
   assumes the one-hot state codes of fcs_regs.vh and a clk_sys domain */
`include "fcs_regs.vh"
`default_nettype none
// ---------------------------------------------------------------------
// checker
// ---------------------------------------------------------------------
module fcs_seq_asserts #(
  parameter NPART = 8,
  parameter PW = 3
) (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset, active low
  input wire logic cmd_we, // write strobe
  input wire logic [7:0] cmd_code, // command code
  input wire logic op_done, // op finished
  input wire logic [15:0] state_r, // one-hot state
  input wire logic [7:0] status_flags_r, // status flags
  input wire logic [2*NPART-1:0] read_mode_r, // modes
  input wire logic [PW-1:0] active_part_r, // owner
  input wire logic active_r, // op owned
  input wire logic unlock_pulse_r, // unlock pulse
  input wire logic start_pulse_r // start pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // busy states are the four that hold the array
  wire busy = |(state_r & 16'h9208);
  wire w_ers = cmd_we && state_r == `FCS_S_ER_SETUP;
  wire w_sus = cmd_we && state_r == `FCS_S_ER_SUSP;
  property p_ready;
    status_flags_r[7] == !busy;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready flag wrong");
  property p_er_go;
    w_ers && cmd_code == 8'hD0 |=> busy && start_pulse_r && active_r;
  endproperty
  a_er_go: assert property (p_er_go)
    else $error("erase not started");
  property p_er_bad;
    w_ers && cmd_code != 8'hD0 |=> !busy && status_flags_r[5:4] == 2'b11;
  endproperty
  a_er_bad: assert property (p_er_bad)
    else $error("no setup error");
  property p_lock;
    cmd_we && state_r == `FCS_S_LOCK_SETUP |=> state_r == `FCS_S_READY &&
      unlock_pulse_r == $past(cmd_code == 8'hD0);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock setup exit wrong");
  property p_clr;
    |($past(status_flags_r) & ~status_flags_r & 8'h1A) |->
      $past(cmd_we && cmd_code == 8'h50);
  endproperty
  a_clr: assert property (p_clr)
    else $error("error flag lost");
  property p_owner;
    active_r && $past(active_r) |-> $stable(active_part_r);
  endproperty
  a_owner: assert property (p_owner)
    else $error("owner changed");
  property p_mode;
    !$past(cmd_we) |-> $stable(read_mode_r);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode changed alone");
  property p_resume;
    w_sus && cmd_code == 8'hD0 |=> state_r == `FCS_S_ER_BUSY;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no resume");
  property p_nest;
    w_sus && (cmd_code == 8'h10 || cmd_code == 8'h40) |=>
      state_r == `FCS_S_ES_WP_SETUP;
  endproperty
  a_nest: assert property (p_nest)
    else $error("no nested setup");
  property p_done;
    !cmd_we && op_done && state_r == `FCS_S_ER_BUSY |=>
      state_r == `FCS_S_READY && !active_r;
  endproperty
  a_done: assert property (p_done)
    else $error("erase end wrong");
endmodule // fcs_seq_asserts
bind fcs_sequencer fcs_seq_asserts #(.NPART(NPART), .PW(PW)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .cmd_we(cmd_we), .cmd_code(cmd_code),
  .op_done(op_done), .state_r(state_r), .status_flags_r(status_flags_r),
  .read_mode_r(read_mode_r), .active_part_r(active_part_r),
  .active_r(active_r), .unlock_pulse_r(unlock_pulse_r),
  .start_pulse_r(start_pulse_r));
`default_nettype wire

// File: bench/flash_command_state_machine_tb_top.sv
/* testbench of the flash command sequencer with the array model.
   assumes each taken write shows in the state one edge later */
`include "fcs_regs.vh"
`default_nettype none
// ---------------------------------------------------------------------
// testbench
// ---------------------------------------------------------------------
module flash_command_state_machine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rstn = 0, cmd_we = 0, err = 0;
  logic [7:0] cmd_code = 8'h00;
  logic [2:0] cmd_part = 3'h0, p;
  logic [3:0] dly = 4'hF;
  logic [31:0] rs = 32'h00000060;
  wire op_done, buf_full, vpp_bad, act, unl, sta;
  wire [15:0] st, rm;
  wire [7:0] sf;
  wire [2:0] ap;
  int bad_count = 0, checked = 0;
  logic [7:0] cl [12] = '{8'hFF, 8'h10, 8'h40, 8'hE8, 8'h20, 8'hD0,
    8'hB0, 8'h70, 8'h50, 8'h90, 8'h98, 8'h60};
  always #5 clk_sys = ~clk_sys;
  fcs_sequencer #(.NPART(8), .PW(3)) i_dut (.clk_sys(clk_sys), .rstn(rstn),
    .cmd_we(cmd_we), .cmd_code(cmd_code), .cmd_part(cmd_part),
    .op_done(op_done), .buf_full(buf_full), .vpp_bad(vpp_bad), .state_r(st),
    .status_flags_r(sf), .read_mode_r(rm), .active_part_r(ap),
    .active_r(act), .unlock_pulse_r(unl), .start_pulse_r(sta));
  fcs_array_model i_arr (.clk_sys(clk_sys), .rstn(rstn), .state_r(st),
    .dly(dly), .err(err), .op_done(op_done), .buf_full(buf_full),
    .vpp_bad(vpp_bad));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // expected state after one write from ready
  function automatic logic [15:0] nx(input logic [7:0] c);
    case (c)
      8'h10, 8'h40: return `FCS_S_WP_SETUP;
      8'hE8: return `FCS_S_BP_SETUP;
      8'h20: return `FCS_S_ER_SETUP;
      8'h60: return `FCS_S_LOCK_SETUP;
      default: return `FCS_S_READY;
    endcase
  endfunction
  function automatic logic [15:0] md(input logic [7:0] c);
    return c == 8'h70 ? 16'h3 : c == 8'h90 ? 16'h1 : c == 8'h98 ? 16'h2 : 0;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [2:0] q);
    @(negedge clk_sys);
    cmd_we = 1;
    cmd_code = c;
    cmd_part = q;
    @(negedge clk_sys);
    cmd_we = 0;
  endtask
  // bounded wait for an operation to end
  task automatic wt(input logic [15:0] e);
    for (int i = 0; i < 60 && st !== e; i++) @(negedge clk_sys);
    chk("state after op", e, st);
  endtask
  task automatic rst;
    @(negedge clk_sys);
    rstn = 0;
    repeat (6) @(negedge clk_sys);
    rstn = 1;
  endtask
  task automatic stop_test;
    $display("counts: %0d checked, %0d mismatched", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
  // each code but factory setup (80h) from ready, then every scenario in turn
  initial begin
    rst;
    foreach (cl[i]) begin
      rs = xs(rs);
      wr(cl[i], rs[2:0]);
      chk("state from ready", nx(cl[i]), st);
      if (cl[i] inside {8'hFF, 8'h70, 8'h90, 8'h98})
        chk("read mode", md(cl[i]), {14'h0, rm[2*rs[2:0] +: 2]});
      rst;
    end
    $display("decode test done");
    p = {1'b0, rs[1:0]};
    wr(8'h98, 3'h5);
    wr(8'h20, p);
    wr(8'hD0, p);
    chk("erase owner", {13'h0, p}, {13'h0, ap});
    chk("op owned", 16'h1, {15'h0, act});
    chk("start pulse", 16'h1, {15'h0, sta});
    wr(8'h70, 3'h4);
    chk("busy on mode write", `FCS_S_ER_BUSY, st);
    wt(`FCS_S_READY);
    chk("mode kept", 16'h2, {14'h0, rm[11:10]});
    chk("ready bit", 16'h1, {15'h0, sf[7]});
    $display("erase test done");
    wr(8'h20, 3'h1);
    wr(8'hD0, 3'h1);
    wr(8'hB0, 3'h1);
    wr(8'h70, 3'h1);
    wr(8'hB0, 3'h1);
    chk("still suspended", `FCS_S_ER_SUSP, st);
    chk("suspend flags", 16'h00C0, {8'h0, sf});
    wr(8'h40, 3'h2);
    chk("nested setup", `FCS_S_ES_WP_SETUP, st);
    dly = 4'h2;
    wr(8'h5A, 3'h2);
    wt(`FCS_S_ER_SUSP);
    wr(8'hD0, 3'h1);
    chk("resumed", `FCS_S_ER_BUSY, st);
    wt(`FCS_S_READY);
    $display("suspend test done");
    rs = xs(rs);
    wr(8'h20, 3'h0);
    wr(rs[7:0] == 8'hD0 ? 8'h00 : rs[7:0], 3'h0);
    chk("setup error", 16'h00B0, {8'h0, sf});
    wr(8'hFF, 3'h0);
    chk("flags kept", 16'h00B0, {8'h0, sf});
    wr(8'h50, 3'h0);
    chk("flags cleared", 16'h0080, {8'h0, sf});
    wr(8'h60, 3'h3);
    wr(8'hD0, 3'h3);
    chk("unlock", `FCS_S_READY, st);
    chk("unlock pulse", 16'h1, {15'h0, unl});
    chk("unlock flags", 16'h0080, {8'h0, sf});
    wr(8'h60, 3'h3);
    wr(8'h2C, 3'h3);
    chk("lock error", `FCS_S_READY, st);
    chk("no unlock pulse", 16'h0, {15'h0, unl});
    chk("lock abort flag", 16'h0082, {8'h0, sf});
    $display("error test done");
    // random stream; the checker judges each step
    repeat (150) begin
      rs = xs(rs);
      dly = rs[11:8];
      err = rs[12] & rs[13] & rs[14];
      wr(cl[rs[7:4] % 12], rs[2:0]);
    end
    $display("random test done");
    stop_test;
  end
endmodule // flash_command_state_machine_tb_top
`default_nettype wire

// File: hw/fcs_regs.vh
/*
  constants for the flash command sequencer: command codes, state codes,
  status flag bit positions and widths.
  assumes inclusion by bare name from the design file.
*/
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
// ---------------------------------------------------------------------
// command codes
// ---------------------------------------------------------------------
`define FCS_CMD_READ_ARRAY 8'hFF
`define FCS_CMD_WORD_PGM_A 8'h10
`define FCS_CMD_WORD_PGM_B 8'h40
`define FCS_CMD_BUF_PGM 8'hE8
`define FCS_CMD_ERASE_SETUP 8'h20
`define FCS_CMD_FACTORY_SETUP 8'h80
`define FCS_CMD_CONFIRM 8'hD0
`define FCS_CMD_SUSPEND 8'hB0
`define FCS_CMD_READ_STATUS 8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_READ_ID 8'h90
`define FCS_CMD_READ_QUERY 8'h98
`define FCS_CMD_LOCK_SETUP 8'h60
// ---------------------------------------------------------------------
// one-hot state codes
// ---------------------------------------------------------------------
`define FCS_NST 16
`define FCS_S_READY 16'h0001
`define FCS_S_LOCK_SETUP 16'h0002
`define FCS_S_WP_SETUP 16'h0004
`define FCS_S_WP_BUSY 16'h0008
`define FCS_S_WP_SUSP 16'h0010
`define FCS_S_BP_SETUP 16'h0020
`define FCS_S_BP_LOAD1 16'h0040
`define FCS_S_BP_LOAD2 16'h0080
`define FCS_S_BP_CONFIRM 16'h0100
`define FCS_S_BP_BUSY 16'h0200
`define FCS_S_BP_SUSP 16'h0400
`define FCS_S_ER_SETUP 16'h0800
`define FCS_S_ER_BUSY 16'h1000
`define FCS_S_ER_SUSP 16'h2000
`define FCS_S_ES_WP_SETUP 16'h4000
`define FCS_S_ES_WP_BUSY 16'h8000
// ---------------------------------------------------------------------
// read modes and status flag bits
// ---------------------------------------------------------------------
`define FCS_RM_ARRAY 2'h0
`define FCS_RM_IDENT 2'h1
`define FCS_RM_QUERY 2'h2
`define FCS_RM_STATUS 2'h3
`define FCS_SR_READY 7
`define FCS_SR_ERASE_SUSP 6
`define FCS_SR_ERASE_ERR 5
`define FCS_SR_PGM_ERR 4
`define FCS_SR_SUPPLY_ERR 3
`define FCS_SR_PGM_SUSP 2
`define FCS_SR_LOCK_ABORT 1
`define FCS_SR_RSVD 0
`define FCS_SR_RESET 8'h80
`endif

// File: hw/fcs_sequencer.v
/*
  flash command sequencer: decodes command writes, steps the chip state,
  keeps a read mode per partition and the status flags.
  assumes cmd_we is a one-cycle strobe from logic on clk_sys; op_done,
  buf_full and vpp_bad come from internal array logic on the same clock.
  limitation: factory programming, one-time programmable setup and the
  buffered and lock paths nested in an erase suspend are not modelled;
  their codes leave the chip state alone.
*/
`include "fcs_regs.vh"
`default_nettype none
module fcs_sequencer #(
  parameter NPART = 8,
  parameter PW = 3
) (
  input wire clk_sys, // system clock
  input wire rstn, // asynchronous reset, active low
  input wire cmd_we, // one-cycle command write strobe
  input wire [7:0] cmd_code, // command code on the bus
  input wire [PW-1:0] cmd_part, // partition addressed by the write
  input wire op_done, // array operation finished
  input wire buf_full, // program buffer load complete
  input wire vpp_bad, // supply out of range during operation
  output reg [`FCS_NST-1:0] state_r, // chip state, one-hot
  output reg [7:0] status_flags_r, // status flags
  output reg [2*NPART-1:0] read_mode_r, // two bits per partition
  output reg [PW-1:0] active_part_r, // partition being programmed or erased
  output reg active_r, // a program or erase is under way
  output reg unlock_pulse_r, // one cycle: unlock the addressed block
  output reg start_pulse_r // one cycle: array operation begins
);
  // ---------------------------------------------------------------------
  // one-hot states, named here so the case below reads like the table
  // ---------------------------------------------------------------------
  // a stray multi-hot value falls to the default branch and back to ready on the next command write
  localparam [`FCS_NST-1:0] S_READY = `FCS_S_READY;
  localparam [`FCS_NST-1:0] S_LOCK_SETUP = `FCS_S_LOCK_SETUP;
  localparam [`FCS_NST-1:0] S_WP_SETUP = `FCS_S_WP_SETUP;
  localparam [`FCS_NST-1:0] S_WP_BUSY = `FCS_S_WP_BUSY;
  localparam [`FCS_NST-1:0] S_WP_SUSP = `FCS_S_WP_SUSP;
  localparam [`FCS_NST-1:0] S_BP_SETUP = `FCS_S_BP_SETUP;
  localparam [`FCS_NST-1:0] S_BP_LOAD1 = `FCS_S_BP_LOAD1;
  localparam [`FCS_NST-1:0] S_BP_LOAD2 = `FCS_S_BP_LOAD2;
  localparam [`FCS_NST-1:0] S_BP_CONFIRM = `FCS_S_BP_CONFIRM;
  localparam [`FCS_NST-1:0] S_BP_BUSY = `FCS_S_BP_BUSY;
  localparam [`FCS_NST-1:0] S_BP_SUSP = `FCS_S_BP_SUSP;
  localparam [`FCS_NST-1:0] S_ER_SETUP = `FCS_S_ER_SETUP;
  localparam [`FCS_NST-1:0] S_ER_BUSY = `FCS_S_ER_BUSY;
  localparam [`FCS_NST-1:0] S_ER_SUSP = `FCS_S_ER_SUSP;
  localparam [`FCS_NST-1:0] S_ES_WP_SETUP = `FCS_S_ES_WP_SETUP;
  localparam [`FCS_NST-1:0] S_ES_WP_BUSY = `FCS_S_ES_WP_BUSY;
  // states that hold the array: they gate op_done and pull ready low;
  // one mask keeps the ready bit and the completion path in step
  localparam [`FCS_NST-1:0] BUSY_MASK = S_WP_BUSY | S_BP_BUSY | S_ER_BUSY |
    S_ES_WP_BUSY;
  reg [`FCS_NST-1:0] state_nxt;
  reg lock_err, seq_err, start_op, unlock;
  wire cmd_wp = (cmd_code == `FCS_CMD_WORD_PGM_A) ||
                (cmd_code == `FCS_CMD_WORD_PGM_B);
  wire cmd_cf = (cmd_code == `FCS_CMD_CONFIRM);
  wire cmd_sus = (cmd_code == `FCS_CMD_SUSPEND);
  wire cmd_clr = cmd_we && (cmd_code == `FCS_CMD_CLEAR_STATUS);
  wire busy_st = |(state_r & BUSY_MASK);
  wire busy_nxt = |(state_nxt & BUSY_MASK);
  // ---------------------------------------------------------------------
  // next state: read modes are deliberately not an input here
  // ---------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    lock_err = 1'b0;
    seq_err = 1'b0;
    start_op = 1'b0;
    unlock = 1'b0;
    if (cmd_we) begin
      case (state_r)
        S_READY: begin
          // codes with no entry here leave the chip ready
          if (cmd_wp) state_nxt = S_WP_SETUP;
          else if (cmd_code == `FCS_CMD_BUF_PGM) state_nxt = S_BP_SETUP;
          else if (cmd_code == `FCS_CMD_ERASE_SETUP)
            state_nxt = S_ER_SETUP;
          else if (cmd_code == `FCS_CMD_LOCK_SETUP)
            state_nxt = S_LOCK_SETUP;
        end
        S_LOCK_SETUP: begin
          state_nxt = S_READY;
          if (cmd_cf) unlock = 1'b1;
          else lock_err = 1'b1;
        end
        // word program: any data write after setup starts it
        S_WP_SETUP: begin
          state_nxt = S_WP_BUSY;
          start_op = 1'b1;
        end
        S_WP_BUSY: if (cmd_sus) state_nxt = S_WP_SUSP;
        S_WP_SUSP: if (cmd_cf) state_nxt = S_WP_BUSY;
        // buffered program: two load steps, then wait for a full buffer
        S_BP_SETUP: state_nxt = S_BP_LOAD1;
        S_BP_LOAD1: state_nxt = S_BP_LOAD2;
        S_BP_LOAD2: if (buf_full) state_nxt = S_BP_CONFIRM;
        S_BP_CONFIRM: begin
          if (cmd_cf) begin
            state_nxt = S_BP_BUSY;
            start_op = 1'b1;
          end else begin
            state_nxt = S_READY;
            seq_err = 1'b1;
          end
        end
        S_BP_BUSY: if (cmd_sus) state_nxt = S_BP_SUSP;
        S_BP_SUSP: if (cmd_cf) state_nxt = S_BP_BUSY;
        // erase, and the word program nested inside its suspend
        S_ER_SETUP: begin
          if (cmd_cf) begin
            state_nxt = S_ER_BUSY;
            start_op = 1'b1;
          end else begin
            state_nxt = S_READY;
            seq_err = 1'b1;
          end
        end
        S_ER_BUSY: if (cmd_sus) state_nxt = S_ER_SUSP;
        S_ER_SUSP: begin
          // status, suspend and the rest keep the erase parked
          if (cmd_wp) state_nxt = S_ES_WP_SETUP;
          else if (cmd_cf) state_nxt = S_ER_BUSY;
        end
        S_ES_WP_SETUP: begin
          state_nxt = S_ES_WP_BUSY;
          start_op = 1'b1;
        end
        S_ES_WP_BUSY: ; // commands are ignored until the nested program ends
        default: state_nxt = S_READY;
      endcase
    end else if (op_done && busy_st) begin
      // completion returns to ready, or back to the suspended erase
      if (state_r == S_ES_WP_BUSY) state_nxt = S_ER_SUSP;
      else state_nxt = S_READY;
    end
  end
  // ---------------------------------------------------------------------
  // state, status flags and one-cycle strobes
  // ---------------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= `FCS_S_READY;
      status_flags_r <= `FCS_SR_RESET;
      active_r <= 1'b0;
      active_part_r <= {PW{1'b0}};
      unlock_pulse_r <= 1'b0;
      start_pulse_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // strobes last one cycle; the sinks must not act on them twice
      unlock_pulse_r <= unlock;
      start_pulse_r <= start_op;
      // ready bit follows the next state, so it agrees with state_r
      status_flags_r[`FCS_SR_READY] <= !busy_nxt;
      status_flags_r[`FCS_SR_ERASE_SUSP] <= state_nxt == S_ER_SUSP;
      status_flags_r[`FCS_SR_PGM_SUSP] <=
        (state_nxt == S_WP_SUSP) || (state_nxt == S_BP_SUSP);
      // reserved bit reads zero
      status_flags_r[`FCS_SR_RSVD] <= 1'b0;
      // error flags: a new error beats a clear in the same cycle
      status_flags_r[`FCS_SR_LOCK_ABORT] <= lock_err ||
        (status_flags_r[`FCS_SR_LOCK_ABORT] && !cmd_clr);
      status_flags_r[`FCS_SR_PGM_ERR] <= seq_err ||
        (status_flags_r[`FCS_SR_PGM_ERR] && !cmd_clr);
      status_flags_r[`FCS_SR_ERASE_ERR] <= seq_err ||
        (status_flags_r[`FCS_SR_ERASE_ERR] && !cmd_clr);
      status_flags_r[`FCS_SR_SUPPLY_ERR] <= (vpp_bad && busy_st) ||
        (status_flags_r[`FCS_SR_SUPPLY_ERR] && !cmd_clr);
      // single owner of the array operation; nested program stays owned
      if (start_op && !active_r) begin
        active_r <= 1'b1;
        active_part_r <= cmd_part;
      end else if (state_nxt == S_READY) begin
        active_r <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------------
  // per-partition read mode, held until a mode command hits it
  // ---------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPART; gi = gi + 1) begin : g_part
      // partition index at the width of cmd_part
      localparam [PW-1:0] PIDX = gi;
      // a mode write lands in any state, busy included; the state machine
      // never reads these bits back
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          read_mode_r[2*gi+1:2*gi] <= `FCS_RM_ARRAY;
        end else if (cmd_we && cmd_part == PIDX) begin
          if (cmd_code == `FCS_CMD_READ_ARRAY)
            read_mode_r[2*gi+1:2*gi] <= `FCS_RM_ARRAY;
          else if (cmd_code == `FCS_CMD_READ_ID)
            read_mode_r[2*gi+1:2*gi] <= `FCS_RM_IDENT;
          else if (cmd_code == `FCS_CMD_READ_QUERY)
            read_mode_r[2*gi+1:2*gi] <= `FCS_RM_QUERY;
          else if (cmd_code == `FCS_CMD_READ_STATUS)
            read_mode_r[2*gi+1:2*gi] <= `FCS_RM_STATUS;
        end
      end
    end
  endgenerate
endmodule // fcs_sequencer
`default_nettype wire
